/* File: logic/slp_pkg.sv */
// package for the sleep mode clock gating block
package slp_pkg;

  // ==========================================================
  // mode encodings (3-bit field)
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_PWRDOWN = 3'h2;
  localparam logic [2:0] MODE_PWRSAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXTSTBY = 3'h7;

  // ==========================================================
  // controller states, gray along run -> sleep -> wake
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE  = 2'h3
  } slp_state_t;

  // ==========================================================
  // clock enables per domain
  typedef struct packed {
    logic cpu;
    logic sram;
    logic timer;
    logic spi;
    logic irq;
    logic main_osc;
    logic async_osc;
  } slp_gate_t;

  localparam slp_gate_t GATE_ALL_ON = 7'h7F;

endpackage : slp_pkg

/* File: logic/slp_ctrl.sv */
// sleep controller: mode select, sleep entry, wake and domain gating
// Function
// [R1] five selectable sleep modes, each with its own gating applied on entry
// [R2] idle stops cpu clock only; sram, timers, spi, interrupts keep running
// [R3] power-down stops oscillator and all functions until interrupt or reset
// [R4] power-save keeps asynchronous timer clocked, everything else asleep
// [R5] standby keeps main oscillator running for fast wake, rest stopped
// [R6] extended standby keeps main oscillator and asynchronous timer running
// [R7] 3-bit mode field and enable bit; sleep only on instruction with enable
`timescale 1ns/1ps

module slp_ctrl (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic             i_cfg_we,
  input  wire logic [2:0]       i_cfg_mode,
  input  wire logic             i_cfg_enable,
  input  wire logic             i_sleep_instr,
  input  wire logic             i_irq_pending,
  output logic [2:0]            o_mode,
  output logic                  o_enable,
  output logic                  o_asleep,
  output logic                  o_wake,
  output slp_pkg::slp_gate_t    o_gate
);

  // ==========================================================
  // configuration
  logic [2:0] mode_q;
  logic [2:0] mode_d;
  logic       en_q;
  logic       en_d;

  // [R7] mode field store
  always_comb
  begin
    mode_d = mode_q;
    en_d   = en_q;
    if (i_cfg_we)
    begin
      mode_d = i_cfg_mode;
      en_d   = i_cfg_enable;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q <= slp_pkg::MODE_IDLE;
      en_q   <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      en_q   <= en_d;
    end
  end

  // ==========================================================
  // sleep state machine
  slp_pkg::slp_state_t state_q;
  slp_pkg::slp_state_t state_d;
  logic [2:0]          act_q;
  logic [2:0]          act_d;
  logic                enter;

  // [R7] enter only with enable set
  assign enter = i_sleep_instr && en_q;

  always_comb
  begin
    state_d = state_q;
    act_d   = act_q;
    case (state_q)
      slp_pkg::ST_RUN:
      begin
        if (enter)
        begin
          state_d = slp_pkg::ST_SLEEP;
          act_d   = mode_q;
        end
      end
      // [R3] hold until interrupt
      slp_pkg::ST_SLEEP:
      begin
        if (i_irq_pending)
          state_d = slp_pkg::ST_WAKE;
      end
      slp_pkg::ST_WAKE:
        state_d = slp_pkg::ST_RUN;
      default:
        state_d = slp_pkg::ST_RUN;
    endcase
  end

  // hardware reset leaves sleep through the async clear
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= slp_pkg::ST_RUN;
      act_q   <= slp_pkg::MODE_IDLE;
    end
    else
    begin
      state_q <= state_d;
      act_q   <= act_d;
    end
  end

  // ==========================================================
  // domain gating
  slp_pkg::slp_gate_t gate_d;
  slp_pkg::slp_gate_t gate_q;

  // [R1] per-mode gating table
  always_comb
  begin
    gate_d = slp_pkg::GATE_ALL_ON;
    if (state_d == slp_pkg::ST_SLEEP)
    begin
      gate_d = '0;
      case (act_d)
        // [R2] idle keeps peripherals
        slp_pkg::MODE_IDLE:
        begin
          gate_d.sram      = 1'b1;
          gate_d.timer     = 1'b1;
          gate_d.spi       = 1'b1;
          gate_d.irq       = 1'b1;
          gate_d.main_osc  = 1'b1;
          gate_d.async_osc = 1'b1;
        end
        // [R3] everything stopped
        slp_pkg::MODE_PWRDOWN:
          gate_d = '0;
        // [R4] async timer only
        slp_pkg::MODE_PWRSAVE:
          gate_d.async_osc = 1'b1;
        // [R5] main oscillator only
        slp_pkg::MODE_STANDBY:
          gate_d.main_osc = 1'b1;
        // [R6] both oscillators
        slp_pkg::MODE_EXTSTBY:
        begin
          gate_d.main_osc  = 1'b1;
          gate_d.async_osc = 1'b1;
        end
        // reserved codes behave as power-down, the safest choice
        default:
          gate_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gate_q <= slp_pkg::GATE_ALL_ON;
    else
      gate_q <= gate_d;
  end

  assign o_gate   = gate_q;
  assign o_mode   = mode_q;
  assign o_enable = en_q;
  assign o_asleep = (state_q == slp_pkg::ST_SLEEP);
  assign o_wake   = (state_q == slp_pkg::ST_WAKE);

  // ==========================================================
  // checks

  chk_enter_gated: assert property (  // [R7]
    @(posedge i_clock) disable iff (!i_rst_n)
    (state_q == slp_pkg::ST_RUN && i_sleep_instr && !en_q) |=> !o_asleep)
    else $error("sleep entered without enable");

  chk_enter_taken: assert property (  // [R1]
    @(posedge i_clock) disable iff (!i_rst_n)
    (state_q == slp_pkg::ST_RUN && i_sleep_instr && en_q) |=> o_asleep && !o_gate.cpu)
    else $error("sleep not entered");

  chk_idle_gating: assert property (  // [R2]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && act_q == slp_pkg::MODE_IDLE) |->
      !o_gate.cpu && o_gate.sram && o_gate.timer && o_gate.spi && o_gate.irq)
    else $error("idle gating wrong");

  chk_pdown_gating: assert property (  // [R3]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && act_q == slp_pkg::MODE_PWRDOWN) |-> o_gate == '0)
    else $error("power-down gating wrong");

  chk_pdown_hold: assert property (  // [R3]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && !i_irq_pending) |=> o_asleep)
    else $error("left sleep without interrupt");

  chk_wake_path: assert property (  // [R3]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && i_irq_pending) |=> o_wake ##1 (o_gate == slp_pkg::GATE_ALL_ON))
    else $error("wake sequence wrong");

  chk_wake_refuse: assert property (  // [R7]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_wake && i_sleep_instr) |=> !o_asleep)
    else $error("sleep taken during wake");

  chk_psave_gating: assert property (  // [R4]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && act_q == slp_pkg::MODE_PWRSAVE) |-> o_gate.async_osc && !o_gate.main_osc)
    else $error("power-save gating wrong");

  chk_stby_gating: assert property (  // [R5]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && act_q == slp_pkg::MODE_STANDBY) |-> o_gate.main_osc && !o_gate.async_osc)
    else $error("standby gating wrong");

  chk_extstby_gating: assert property (  // [R6]
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_asleep && act_q == slp_pkg::MODE_EXTSTBY) |->
      o_gate.main_osc && o_gate.async_osc && !o_gate.timer)
    else $error("extended standby gating wrong");

endmodule : slp_ctrl

/* File: verification/tb_slp_ctrl.sv */
// self-checking bench for the sleep mode clock gating block
`timescale 1ns/1ps

module tb_slp_ctrl;
  // ==========================================================
  // signals
  logic               i_clock;
  logic               i_rst_n;
  logic               i_cfg_we;
  logic [2:0]         i_cfg_mode;
  logic               i_cfg_enable;
  logic               i_sleep_instr;
  logic               i_irq_pending;
  logic [2:0]         o_mode;
  logic               o_enable;
  logic               o_asleep;
  logic               o_wake;
  slp_pkg::slp_gate_t o_gate;
  int                 bad_count;
  int                 checks;
  int                 cycles;

  slp_ctrl dut (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_cfg_we     (i_cfg_we),
    .i_cfg_mode   (i_cfg_mode),
    .i_cfg_enable (i_cfg_enable),
    .i_sleep_instr(i_sleep_instr),
    .i_irq_pending(i_irq_pending),
    .o_mode       (o_mode),
    .o_enable     (o_enable),
    .o_asleep     (o_asleep),
    .o_wake       (o_wake),
    .o_gate       (o_gate)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // ==========================================================
  // compare and drive tasks
  task automatic cmp_val(input string n, input logic [2:0] e, input logic [2:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val

  task automatic cmp_gate(input string n, input slp_pkg::slp_gate_t e);
    checks++;
    if (o_gate !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, o_gate);
    end
  endtask : cmp_gate

  task automatic write_cfg(input logic [2:0] m, input logic e);
    @(posedge i_clock);
    i_cfg_we     <= 1'b1;
    i_cfg_mode   <= m;
    i_cfg_enable <= e;
    @(posedge i_clock);
    i_cfg_we <= 1'b0;
    #1;
    cmp_val("mode", m, o_mode);
    cmp_val("enable", {2'h0, e}, {2'h0, o_enable});
  endtask : write_cfg

  task automatic pulse_sleep;
    @(posedge i_clock);
    i_sleep_instr <= 1'b1;
    @(posedge i_clock);
    i_sleep_instr <= 1'b0;
    #1;
  endtask : pulse_sleep

  // ==========================================================
  // scenarios
  task automatic run_mode(input logic [2:0] m, input slp_pkg::slp_gate_t p);
    write_cfg(m, 1'b1);
    pulse_sleep();
    cmp_val("asleep", 3'h1, {2'h0, o_asleep});
    cmp_gate("gate entry", p);
    // a second sleep instruction while asleep must change nothing
    pulse_sleep();
    repeat (3) @(posedge i_clock);
    #1;
    cmp_gate("gate held", p);
    @(posedge i_clock);
    i_irq_pending <= 1'b1;
    @(posedge i_clock);
    i_irq_pending <= 1'b0;
    #1;
    cmp_val("wake", 3'h1, {2'h0, o_wake});
    cmp_val("awake", 3'h0, {2'h0, o_asleep});
    cmp_gate("gate wake", 7'h7F);
    @(posedge i_clock);
    #1;
    cmp_val("wake end", 3'h0, {2'h0, o_wake});
  endtask : run_mode

  task automatic check_idle_outputs(input string n);
    cmp_val({n, " mode"}, 3'h0, o_mode);
    cmp_val({n, " enable"}, 3'h0, {2'h0, o_enable});
    cmp_val({n, " asleep"}, 3'h0, {2'h0, o_asleep});
    cmp_val({n, " wake"}, 3'h0, {2'h0, o_wake});
    cmp_gate({n, " gate"}, 7'h7F);
  endtask : check_idle_outputs

  task automatic tst_no_enable;
    write_cfg(slp_pkg::MODE_PWRDOWN, 1'b0);
    pulse_sleep();
    cmp_val("no sleep", 3'h0, {2'h0, o_asleep});
    cmp_gate("no gate", 7'h7F);
  endtask : tst_no_enable

  task automatic tst_sleep_write;
    write_cfg(slp_pkg::MODE_STANDBY, 1'b1);
    pulse_sleep();
    cmp_gate("stby entry", 7'h02);
    // a write during sleep is stored but only acts on the next entry
    write_cfg(slp_pkg::MODE_PWRSAVE, 1'b1);
    cmp_gate("stby kept", 7'h02);
    @(posedge i_clock);
    i_irq_pending <= 1'b1;
    @(posedge i_clock);
    i_irq_pending <= 1'b0;
    i_sleep_instr <= 1'b1;
    #1;
    cmp_val("rewake", 3'h1, {2'h0, o_wake});
    @(posedge i_clock);
    #1;
    cmp_val("wake refuse", 3'h0, {2'h0, o_asleep});
    @(posedge i_clock);
    i_sleep_instr <= 1'b0;
    #1;
    cmp_val("resleep", 3'h1, {2'h0, o_asleep});
    cmp_gate("psave entry", 7'h01);
    @(posedge i_clock);
    i_irq_pending <= 1'b1;
    @(posedge i_clock);
    i_irq_pending <= 1'b0;
    #1;
    cmp_gate("psave wake", 7'h7F);
  endtask : tst_sleep_write

  task automatic tst_reset_exit;
    write_cfg(slp_pkg::MODE_PWRDOWN, 1'b1);
    pulse_sleep();
    cmp_gate("pdown before reset", 7'h00);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    #1;
    check_idle_outputs("reset exit");
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    #1;
    check_idle_outputs("after reset");
  endtask : tst_reset_exit

  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // hang guard, run needs about 100 cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    i_rst_n       = 1'b0;
    i_cfg_we      = 1'b0;
    i_cfg_mode    = 3'h0;
    i_cfg_enable  = 1'b0;
    i_sleep_instr = 1'b0;
    i_irq_pending = 1'b0;
    repeat (7) @(posedge i_clock);
    #1;
    check_idle_outputs("rst");
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    tst_no_enable();
    run_mode(slp_pkg::MODE_IDLE, 7'h3F);
    run_mode(slp_pkg::MODE_PWRDOWN, 7'h00);
    run_mode(slp_pkg::MODE_PWRSAVE, 7'h01);
    run_mode(slp_pkg::MODE_STANDBY, 7'h02);
    run_mode(slp_pkg::MODE_EXTSTBY, 7'h03);
    run_mode(3'h1, 7'h00);
    tst_sleep_write();
    tst_reset_exit();
    wrap_up();
  end
endmodule : tb_slp_ctrl
